// ### verilog/psu_map.svh
/*
 * register map, bit positions and reset values of the power saving unit.
 * assumes it is included once per compile unit by its bare name.
 */
// Overview of operation
// [RL1] four word registers from base ffff4000
// [RL2] control bit 0 one stops core clock
// [RL3] enabled interrupt or reset restarts core clock
// [RL4] core runs after reset, wakes unaided
// [RL5] enable command sets peripheral clock bits
// [RL6] disable command clears peripheral clock bits
// [RL7] status shows enabled clocks, resets 17c
// [RL8] all peripheral clocks enabled on reset
// [RL9] disabled clock stops at once
// [RL10] gating keeps peripheral state intact
// [RL11] clock bits match interrupt source numbers
// [RL12] software disables only idle peripherals
// [RL13] interrupt mask decides which interrupts wake
// [RL14] unassigned bits read zero, writes ignored
// [RL15] clock gating switches without glitches
`ifndef PSU_MAP_SVH
`define PSU_MAP_SVH

// block decode: base address and the bits that select the block
`define PSU_BASE 32'hffff4000
`define PSU_BASE_MASK 32'hfffffff0

// word offsets inside the block
`define PSU_OFS_CTRL 4'h0
`define PSU_OFS_ENA 4'h4
`define PSU_OFS_DIS 4'h8
`define PSU_OFS_STAT 4'hc

// control register: core clock stop command
`define PSU_CPU_BIT 0

// peripheral bit positions, same as their interrupt source numbers
`define PSU_BIT_SER0 2
`define PSU_BIT_SER1 3
`define PSU_BIT_TMR0 4
`define PSU_BIT_TMR1 5
`define PSU_BIT_TMR2 6
`define PSU_BIT_PARIO 8

// width of the peripheral field, implemented bits and reset value
`define PSU_NPERIPH 9
`define PSU_PERIPH_MASK 9'h17c
`define PSU_STAT_RESET 9'h17c

`endif

// ### verilog/psu_pkg.sv
/*
 * types shared by the power saving unit files.
 * assumes psu_map.svh is compiled alongside.
 */
`default_nettype none
package psu_pkg;
    // one register bus request, as the master drives it
    typedef struct packed {
        logic [31:0] addr;  // byte address
        logic [31:0] wdata; // write data
        logic wr;           // write strobe
        logic rd;           // read strobe
    } psu_bus_t;

    // core clock state, one-hot
    typedef enum logic [1:0] {
        PSU_CORE_RUN = 2'b01,
        PSU_CORE_IDLE = 2'b10
    } psu_core_t;
endpackage
`default_nettype wire

// ### verilog/psu_clk_gate.sv
/*
 * glitch-free clock gate: an enable caught on the falling edge ands
 * the clock. assumes i_en changes only just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module psu_clk_gate (
    input wire logic i_clk, // clock to gate
    input wire logic i_rst, // synchronous reset, high
    input wire logic i_ce,  // freezes the enable while low
    input wire logic i_en,  // wanted clock enable
    output logic o_gclk     // gated clock
);
    logic en_q; // enable held through the high phase

    // caught while the clock is low, so a change never cuts a high pulse
    always_ff @(negedge i_clk) begin
        if (i_rst) begin
            en_q <= 1'b1; // clocks run during and after reset
        end else if (i_ce) begin
            en_q <= i_en; // [RL15] [RL9]
        end
    end

    // the and only opens or closes while the clock is low
    assign o_gclk = i_clk & en_q; // [RL15]

    // the gate follows its enable within half a cycle
    property p_gate_follow;
        @(posedge i_clk) disable iff (i_rst)
        i_ce |-> en_q == i_en;
    endproperty
    a_gate_follow: assert property (p_gate_follow) // [RL9]
        else $error("gate enable lags its request");

    // no high pulse while the enable is low
    property p_gate_quiet;
        @(negedge i_clk) disable iff (i_rst)
        !en_q |-> !o_gclk;
    endproperty
    a_gate_quiet: assert property (p_gate_quiet) // [RL15]
        else $error("gated clock high while disabled");
endmodule
`default_nettype wire

// ### verilog/psu_top.sv
/*
 * power saving unit: core clock idle control and per-peripheral
 * clock gating behind four word registers.
 * assumes one clock, a synchronous high reset, a one-cycle bus master
 * and an interrupt controller that supplies pending and mask words.
 */
`timescale 1ns/1ps
`default_nettype none
`include "psu_map.svh"
module psu_top
    import psu_pkg::*;
#(
    parameter int IRQ_W = 32 // interrupt source count
) (
    input wire logic i_sys_clk,           // master clock
    input wire logic i_rst,               // synchronous reset, high
    input wire logic i_ce,                // freezes all state when low
    input wire psu_bus_t i_bus,           // register bus request
    input wire logic [IRQ_W-1:0] i_irq_pend, // pending sources
    input wire logic [IRQ_W-1:0] i_irq_mask, // enabled sources
    output logic [31:0] o_rdata,          // read data, next cycle
    output logic o_core_clk,              // gated core clock
    output logic o_core_idle,             // core clock stopped
    output logic [`PSU_NPERIPH-1:0] o_periph_clk // gated clocks
);
    localparam int NP = `PSU_NPERIPH;
    // implemented peripheral bits
    localparam logic [NP-1:0] PMASK = `PSU_PERIPH_MASK;
    // state after reset
    localparam logic [NP-1:0] PRESET = `PSU_STAT_RESET;

    // address decode
    logic hit;             // address falls in this block
    logic [3:0] ofs;       // byte offset inside the block
    logic wr_ctrl;         // control register write
    logic wr_ena;          // enable command write
    logic wr_dis;          // disable command write
    logic rd_stat;         // status register read
    logic [NP-1:0] wbits;  // write data cut to implemented bits

    // the block answers only at its own base
    assign hit = (i_bus.addr & `PSU_BASE_MASK) == `PSU_BASE; // [RL1]
    assign ofs = i_bus.addr[3:0];
    // strobes qualified by the clock enable, so a frozen cycle is lost
    assign wr_ctrl = i_ce & i_bus.wr & hit & (ofs == `PSU_OFS_CTRL);
    assign wr_ena = i_ce & i_bus.wr & hit & (ofs == `PSU_OFS_ENA);
    assign wr_dis = i_ce & i_bus.wr & hit & (ofs == `PSU_OFS_DIS);
    assign rd_stat = i_ce & i_bus.rd & hit & (ofs == `PSU_OFS_STAT);
    // unassigned bits never reach the clock state
    assign wbits = i_bus.wdata[NP-1:0] & PMASK; // [RL14]

    // core clock control
    psu_core_t core_q;  // running or idle
    psu_core_t core_d;  // next core state
    logic wake;         // some enabled interrupt is pending
    logic stop_req;     // software asks to stop the core

    // only sources the interrupt controller has enabled may wake
    assign wake = |(i_irq_pend & i_irq_mask); // [RL13]
    // a zero in bit 0 is no command at all
    assign stop_req = wr_ctrl & i_bus.wdata[`PSU_CPU_BIT]; // [RL2]

    // next core state
    always_comb begin
        core_d = core_q;
        case (core_q)
            PSU_CORE_RUN: begin
                if (stop_req) begin
                    core_d = PSU_CORE_IDLE; // [RL2]
                end
            end
            PSU_CORE_IDLE: begin
                // wake needs no software, which cannot run anyway
                if (wake) begin
                    core_d = PSU_CORE_RUN; // [RL3] [RL4]
                end
            end
            default: begin
                core_d = PSU_CORE_RUN; // illegal code recovers to run
            end
        endcase
    end

    // core state register; a wake pending on entry ends idle next cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            core_q <= PSU_CORE_RUN; // [RL3] [RL4]
        end else if (i_ce) begin
            core_q <= core_d;
        end
    end

    assign o_core_idle = (core_q == PSU_CORE_IDLE);

    // peripheral clock enables
    logic [NP-1:0] pen_q; // enabled peripheral clocks
    logic [NP-1:0] pen_d; // next enables
    logic [NP-1:0] set_v; // bits to turn on
    logic [NP-1:0] clr_v; // bits to turn off

    // set/clear commands: zero bits leave the clock as it is
    assign set_v = wr_ena ? wbits : '0; // [RL5] [RL11]
    assign clr_v = wr_dis ? wbits : '0; // [RL6] [RL11]
    // strobes never coincide, so set and clear cannot collide
    assign pen_d = (pen_q | set_v) & ~clr_v;

    // enable register; nothing here resets a peripheral
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pen_q <= PRESET; // [RL8]
        end else if (i_ce) begin
            pen_q <= pen_d; // [RL5] [RL6]
        end
    end

    // read data: status only, write-only and unmapped words read zero
    logic [31:0] rdata_q; // read answer
    logic [31:0] rdata_d; // answer for this cycle's read

    assign rdata_d = rd_stat ? {{(32-NP){1'b0}}, pen_q & PMASK}
                             : 32'h0000_0000; // [RL7] [RL14]

    // the answer stands for exactly the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            rdata_q <= rdata_d; // [RL7]
        end
    end

    assign o_rdata = rdata_q;

    // core clock gate; the gate itself forces the clock on in reset
    psu_clk_gate u_core_gate (
        .i_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_en(core_q == PSU_CORE_RUN), // [RL3]
        .o_gclk(o_core_clk)
    );

    // one gate per implemented peripheral; clock stops without any
    // handshake, so software must first let the peripheral finish
    // (a stopped peripheral keeps all its flops, and simply resumes)
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi = gi + 1) begin : g_per
            if (PMASK[gi]) begin : g_on
                psu_clk_gate u_gate (
                    .i_clk(i_sys_clk),
                    .i_rst(i_rst),
                    .i_ce(i_ce),
                    .i_en(pen_q[gi]), // [RL9] [RL10]
                    .o_gclk(o_periph_clk[gi])
                );
            end else begin : g_off
                // unassigned positions have no peripheral to clock
                assign o_periph_clk[gi] = 1'b0; // [RL14]
            end
        end
    endgenerate

    // a status read returns the enables in the next cycle
    property p_stat_read;
        @(posedge i_sys_clk) disable iff (i_rst)
        rd_stat |=> o_rdata == {{(32-NP){1'b0}}, $past(pen_q)};
    endproperty
    a_stat_read: assert property (p_stat_read) // [RL7]
        else $error("status read data wrong");

    // any other read answers zero
    property p_other_read;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && i_bus.rd && !rd_stat) |=> o_rdata == 32'h0000_0000;
    endproperty
    a_other_read: assert property (p_other_read) // [RL1]
        else $error("non-status read not zero");

    // a stop command idles a running core
    property p_stop;
        @(posedge i_sys_clk) disable iff (i_rst)
        (stop_req && core_q == PSU_CORE_RUN) |=> o_core_idle;
    endproperty
    a_stop: assert property (p_stop) // [RL2]
        else $error("core did not stop");

    // writing zero to the control register keeps the core running
    property p_stop_zero;
        @(posedge i_sys_clk) disable iff (i_rst)
        (wr_ctrl && !i_bus.wdata[`PSU_CPU_BIT] && !o_core_idle)
            |=> !o_core_idle;
    endproperty
    a_stop_zero: assert property (p_stop_zero) // [RL2]
        else $error("zero write stopped the core");

    // an enabled pending interrupt ends idle in one cycle
    property p_wake;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && o_core_idle && wake) |=> !o_core_idle;
    endproperty
    a_wake: assert property (p_wake) // [RL3]
        else $error("enabled interrupt did not wake core");

    // a masked interrupt alone never wakes the core
    property p_no_wake;
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_core_idle && !wake) |=> o_core_idle;
    endproperty
    a_no_wake: assert property (p_no_wake) // [RL13]
        else $error("core woke without an enabled interrupt");

    // first cycle after reset: core running, all clocks on
    property p_after_reset;
        @(posedge i_sys_clk)
        $past(i_rst) && !i_rst |-> !o_core_idle && pen_q == PRESET;
    endproperty
    a_after_reset: assert property (p_after_reset) // [RL4] [RL8]
        else $error("wrong state after reset");

    // enable command turns on written bits, keeps the others
    property p_enable;
        @(posedge i_sys_clk) disable iff (i_rst)
        wr_ena |=> pen_q == ($past(pen_q) | $past(wbits));
    endproperty
    a_enable: assert property (p_enable) // [RL5]
        else $error("enable command misapplied");

    // disable command turns off written bits, keeps the others
    property p_disable;
        @(posedge i_sys_clk) disable iff (i_rst)
        wr_dis |=> pen_q == ($past(pen_q) & ~$past(wbits));
    endproperty
    a_disable: assert property (p_disable) // [RL6] [RL9]
        else $error("disable command misapplied");

    // unassigned bits never become enabled
    property p_unassigned;
        @(posedge i_sys_clk) disable iff (i_rst)
        (pen_q & ~PMASK) == '0;
    endproperty
    a_unassigned: assert property (p_unassigned) // [RL14]
        else $error("unassigned clock bit set");

    // state holds while the clock enable is low
    property p_freeze;
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_ce |=> $stable(pen_q) && $stable(core_q) && $stable(o_rdata);
    endproperty
    a_freeze: assert property (p_freeze) // [RL10]
        else $error("state moved while frozen");

    // high phase of the core clock follows the state one cycle back
    property p_core_clk;
        @(negedge i_sys_clk) disable iff (i_rst)
        $past(i_ce) |-> o_core_clk == $past(!o_core_idle);
    endproperty
    a_core_clk: assert property (p_core_clk) // [RL2] [RL3]
        else $error("core clock disagrees with idle state");

    // each live peripheral clock is high only while it is enabled
    property p_periph_clk;
        @(negedge i_sys_clk) disable iff (i_rst)
        $past(i_ce) |-> (o_periph_clk & PMASK) == $past(pen_q);
    endproperty
    a_periph_clk: assert property (p_periph_clk) // [RL9] [RL11]
        else $error("peripheral clock disagrees with its enable");

    // reset always leaves the core running and every clock enabled
    property p_reset_run;
        @(posedge i_sys_clk)
        i_rst |=> !o_core_idle && pen_q == PRESET;
    endproperty
    a_reset_run: assert property (p_reset_run) // [RL3] [RL8]
        else $error("reset did not restart the clocks");

    // without a read the answer falls back to zero
    property p_rdata_idle;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && !i_bus.rd) |=> o_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // [RL7]
        else $error("read data stood longer than one cycle");

    // unassigned status positions never read as one
    property p_stat_reserved;
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_rdata & ~{{(32-NP){1'b0}}, PMASK}) == 32'h0000_0000;
    endproperty
    a_stat_reserved: assert property (p_stat_reserved) // [RL14]
        else $error("unassigned status bit read as one");

    // the control word never touches the peripheral clocks
    property p_ctrl_keeps;
        @(posedge i_sys_clk) disable iff (i_rst)
        wr_ctrl |=> $stable(pen_q);
    endproperty
    a_ctrl_keeps: assert property (p_ctrl_keeps) // [RL2]
        else $error("control write moved a peripheral clock");

    // the read-only status word ignores writes
    property p_stat_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && i_bus.wr && hit && ofs == `PSU_OFS_STAT) |=> $stable(pen_q);
    endproperty
    a_stat_write: assert property (p_stat_write) // [RL1]
        else $error("status write changed the clocks");
endmodule
`default_nettype wire

// ### tb/psu_far_model.sv
/*
 * far side of the power saving unit: the core and the six peripherals,
 * seen as counters of their clock edges plus a pulse width watcher.
 * assumes the gated clocks come straight from the unit, 100 ns period.
 */
`timescale 1ns/1ps
`default_nettype none
`include "psu_map.svh"
module psu_far_model (
    input wire logic i_core_clk,                      // gated core clock
    input wire logic [`PSU_NPERIPH-1:0] i_periph_clk, // gated peripherals
    output int o_core_cnt,                            // core edges seen
    output int o_periph_cnt [`PSU_NPERIPH],           // peripheral edges
    output logic o_glitch                             // short pulse seen
);
    wire logic [`PSU_NPERIPH:0] all_clk; // core on top, peripherals below
    assign all_clk = {i_core_clk, i_periph_clk};
    initial o_glitch = 1'b0;
    initial o_core_cnt = 0;
    // each peripheral only advances on its own clock edges, so a gated
    // clock leaves its count, its whole state, exactly where it stopped
    always @(posedge i_core_clk) o_core_cnt++;
    for (genvar g = 0; g < `PSU_NPERIPH; g++) begin : g_cnt
        initial o_periph_cnt[g] = 0;
        always @(posedge i_periph_clk[g]) o_periph_cnt[g]++;
    end
    // a high phase shorter than 49 ns, just under half the master period, is a glitch
    for (genvar g = 0; g <= `PSU_NPERIPH; g++) begin : g_width
        realtime t_up;
        initial t_up = 0.0;
        always @(posedge all_clk[g]) t_up = $realtime;
        always @(negedge all_clk[g]) begin
            if ($realtime - t_up < 49.0) o_glitch = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### tb/power_saving_clock_gate_test.sv
/*
 * self-checking bench of the power saving unit: register bus tasks,
 * one task per scenario, edge counts taken from the far side model.
 * assumes the unit answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "psu_map.svh"
module power_saving_clock_gate_test;
    import psu_pkg::*;
    logic clk = 1'b0;          // master clock, 100 ns
    logic rst = 1'b1;          // synchronous reset
    logic ce = 1'b1;           // unit clock enable
    psu_bus_t bus = '0;        // register bus request
    logic [31:0] pend = '0;    // pending interrupt sources
    logic [31:0] mask = '0;    // enabled interrupt sources
    logic [31:0] rdata;        // read data
    logic core_clk;            // gated core clock
    logic core_idle;           // core stopped flag
    logic [8:0] pclk;          // gated peripheral clocks
    int ccnt;                  // core edge count
    int pcnt [9];              // peripheral edge counts
    logic glitch;              // short pulse seen
    int fail_count = 0;        // mismatches
    int n_tests = 0;           // comparisons
    logic [31:0] v;            // scratch read value
    always #50 clk = ~clk;
    psu_top #(.IRQ_W(32)) dut (.i_sys_clk(clk), .i_rst(rst), .i_ce(ce),
        .i_bus(bus), .i_irq_pend(pend), .i_irq_mask(mask),
        .o_rdata(rdata), .o_core_clk(core_clk), .o_core_idle(core_idle),
        .o_periph_clk(pclk));
    psu_far_model far (.i_core_clk(core_clk), .i_periph_clk(pclk),
        .o_core_cnt(ccnt), .o_periph_cnt(pcnt), .o_glitch(glitch));
    // compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    // one-cycle write strobe, launched just after an edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    // one-cycle read strobe; the answer stands only in the next cycle
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // count edges over three cycles against the expected enables
    task automatic pulse_chk(input logic [8:0] on, input logic core_on);
        int snap [9];
        int csnap;
        #1;
        snap = pcnt;
        csnap = ccnt;
        repeat (3) @(posedge clk);
        #1;
        for (int i = 0; i < 9; i++)
            chk($sformatf("clock %0d edges", i), snap[i] + (on[i] ? 3 : 0),
                pcnt[i]);
        chk("core clock edges", csnap + (core_on ? 3 : 0), ccnt);
    endtask
    // everything running straight out of reset
    task automatic t_reset;
        rd(32'hffff400c, v);
        chk("status", 32'h17c, v);
        chk("core idle", 32'h0, {31'h0, core_idle});
        pulse_chk(9'h17c, 1'b1);
        $display("test reset done");
    endtask
    // set and clear commands, unassigned bits, immediate stop
    task automatic t_gate;
        wr(32'hffff4008, 32'hffffffff);
        pulse_chk(9'h000, 1'b1);
        rd(32'hffff400c, v);
        chk("status", 32'h0, v);
        wr(32'hffff4004, 32'h00000004);
        pulse_chk(9'h004, 1'b1);
        rd(32'hffff400c, v);
        chk("status", 32'h004, v);
        wr(32'hffff4004, 32'hfffffffb);
        rd(32'hffff400c, v);
        chk("status", 32'h17c, v);
        wr(32'hffff4008, 32'h00000100);
        pulse_chk(9'h07c, 1'b1);
        rd(32'hffff400c, v);
        chk("status", 32'h07c, v);
        wr(32'hffff4004, 32'h00000100);
        pulse_chk(9'h17c, 1'b1);
        $display("test gating done");
    endtask
    // write-only and unmapped places read zero; status and unmapped places ignore writes
    task automatic t_map;
        logic [31:0] adr [5];
        adr = '{32'hffff4000, 32'hffff4004, 32'hffff4008, 32'hffff4010,
                32'hffff4001};
        for (int i = 0; i < 5; i++) begin
            rd(adr[i], v);
            chk("read data", 32'h0, v);
        end
        // all ones, so a status word decoded as a disable command would show
        wr(32'hffff400c, 32'hffffffff);
        wr(32'hffff4018, 32'hffffffff);
        wr(32'hfffe4008, 32'hffffffff);
        rd(32'hffff400c, v);
        chk("status", 32'h17c, v);
        $display("test map done");
    endtask
    // idle entry, masked and unmasked wake, reset wake
    task automatic t_idle;
        @(posedge clk);
        pend <= 32'h4;
        wr(32'hffff4000, 32'hfffffffe);
        pulse_chk(9'h17c, 1'b1);
        wr(32'hffff4000, 32'h1);
        // the idle flag settles only after the edge that takes the write
        #1;
        chk("core idle", 32'h1, {31'h0, core_idle});
        pulse_chk(9'h17c, 1'b0);
        @(posedge clk);
        mask <= 32'h4;
        for (int k = 0; k < 4 && core_idle !== 1'b0; k++) begin
            @(posedge clk);
            #1;
        end
        chk("core idle", 32'h0, {31'h0, core_idle});
        if (core_idle !== 1'b0) summarize();
        pulse_chk(9'h17c, 1'b1);
        @(posedge clk);
        pend <= 32'h0;
        mask <= 32'h0;
        wr(32'hffff4008, 32'h00000010);
        wr(32'hffff4000, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("core idle", 32'h0, {31'h0, core_idle});
        pulse_chk(9'h17c, 1'b1);
        rd(32'hffff400c, v);
        chk("status", 32'h17c, v);
        $display("test idle done");
    endtask
    // clock enable low: commands are lost, gates keep their state
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        wr(32'hffff4008, 32'h0000017c);
        pulse_chk(9'h17c, 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        rd(32'hffff400c, v);
        chk("status", 32'h17c, v);
        $display("test freeze done");
    endtask
    // print the counts and the verdict, then stop
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // main sequence: hold reset, then run every scenario
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_gate();
        t_map();
        t_idle();
        t_freeze();
        chk("short pulse", 32'h0, {31'h0, glitch});
        summarize();
    end
endmodule
`default_nettype wire
